// *** bench/core_model.sv ***
// core side: issues one memory operation per instruction cycle
module core_model (
  // clock
  input  wire        clk,
  // requests
  output logic       cyc_en,
  output logic [9:0] mem_addr,
  output logic       ext_mode,
  output logic       rd_en,
  output logic       wr_mem,
  output logic       wr_acc,
  output logic       bit_op,
  output logic       bit_set,
  output logic [2:0] bit_sel,
  output logic [2:0] alu_op,
  output logic [7:0] imm_data,
  output logic       use_imm
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet at time zero
  initial begin
    {cyc_en, rd_en, wr_mem, wr_acc, bit_op, bit_set, ext_mode, use_imm} = 8'h00;
    {mem_addr, bit_sel, alu_op, imm_data} = 24'h0;
  end
  // kinds: 0 read, 1 write, 2 set, 3 clear, 4 load acc, 5 add acc, 6 store acc
  task op(input x, input [9:0] a, input [7:0] d, input [2:0] f);
    @(negedge clk);
    cyc_en = 1'b1;
    ext_mode = x;
    mem_addr = a;
    imm_data = d;
    use_imm = 1'b1;
    rd_en = (f == 3'h0);
    wr_mem = (f == 3'h1 || f == 3'h2 || f == 3'h3 || f == 3'h6);
    wr_acc = (f == 3'h4 || f == 3'h5);
    bit_op = (f == 3'h2 || f == 3'h3);
    bit_set = (f == 3'h2);
    bit_sel = d[2:0];
    alu_op = (f == 3'h5) ? 3'h2 : (f == 3'h6) ? 3'h1 : 3'h0;
    @(posedge clk);
  endtask
  // one alu step on the accumulator, result to accumulator or to memory
  task calc(input [2:0] c, input [9:0] a, input [7:0] d, input im, input m);
    @(negedge clk);
    cyc_en = 1'b1;
    ext_mode = 1'b1;
    mem_addr = a;
    imm_data = d;
    use_imm = im;
    rd_en = 1'b0;
    wr_mem = m;
    wr_acc = !m;
    bit_op = 1'b0;
    alu_op = c;
    @(posedge clk);
  endtask
  // release: strobes drop, address and data lines no longer hold the last value
  task idle;
    @(negedge clk);
    {cyc_en, rd_en, wr_mem, wr_acc} = 4'h0;
    mem_addr = ~mem_addr;
    imm_data = ~imm_data;
  endtask
endmodule

// *** bench/data_memory_asserts.sv ***
// port-level checks on the data memory block
module data_memory_asserts #(
  parameter [7:0] ID_CODE = 8'h5a
) (
  // clock and reset
  input wire       clk,
  input wire       arst_n,
  // requests
  input wire       cyc_en,
  input wire [9:0] mem_addr,
  input wire       ext_mode,
  input wire       rd_en,
  input wire       wr_mem,
  input wire       wr_acc,
  input wire       bit_op,
  input wire       bit_set,
  input wire [2:0] bit_sel,
  input wire [2:0] alu_op,
  input wire [7:0] imm_data,
  input wire       use_imm,
  // results
  input wire [7:0] rd_data_ff,
  input wire [7:0] acc_out,
  input wire [7:0] eeprom_ctrl_out,
  input wire [7:0] eeprom_status_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // taken read and write, and the extended sector in use
  sequence s_rd; cyc_en && rd_en; endsequence
  sequence s_wr; cyc_en && wr_mem; endsequence
  wire [1:0] sec = ext_mode ? mem_addr[9:8] : 2'h0;
  wire [7:0] ofs = mem_addr[7:0];
  property p_rd_hold; !(cyc_en && rd_en) |=> $stable(rd_data_ff); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_acc_hold; !(cyc_en && (wr_acc || wr_mem)) |=> $stable(acc_out); endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved idle");
  property p_unused_zero; s_rd ##0 (ofs inside {[8'h0a:8'h3f]}) |=> rd_data_ff == 8'h00; endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused place not zero");
  property p_sec3_zero; s_rd ##0 (sec == 2'h3 && ofs[7]) |=> rd_data_ff == 8'h00; endproperty
  a_sec3_zero: assert property (p_sec3_zero) else $error("missing sector not zero");
  property p_lcd_gap; s_rd ##0 (sec == 2'h1 && ofs > 8'h93) |=> rd_data_ff == 8'h00; endproperty
  a_lcd_gap: assert property (p_lcd_gap) else $error("past display area not zero");
  property p_id_read; s_rd ##0 (ofs == 8'h09) |=> rd_data_ff == ID_CODE; endproperty
  a_id_read: assert property (p_id_read) else $error("read-only id wrong");
  property p_ctl_sector; s_wr ##0 (ofs == 8'h40 && sec != 2'h1) |=> $stable(eeprom_ctrl_out);
  endproperty
  a_ctl_sector: assert property (p_ctl_sector) else $error("control reg hit outside");
  property p_ctl_read; s_rd ##0 (sec == 2'h1 && ofs == 8'h40)
    |=> rd_data_ff == ($past(eeprom_ctrl_out) | $past(eeprom_status_in)); endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control reg read wrong");
  property p_load_imm; cyc_en && wr_acc && !wr_mem && !bit_op && use_imm && alu_op == 3'h0
    |=> acc_out == $past(imm_data); endproperty
  a_load_imm: assert property (p_load_imm) else $error("accumulator load wrong");
endmodule
bind data_memory data_memory_asserts #(.ID_CODE(ID_CODE)) i_data_memory_asserts (.*);

// *** bench/tb_data_memory.sv ***
// self-checking bench for the sectored data memory
module tb_data_memory;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [7:0] ID = 8'h3c; // arbitrary value
  logic       clk, arst_n, cyc_en, ext_mode, rd_en, wr_mem, wr_acc, bit_op, bit_set, use_imm;
  logic [9:0] mem_addr;
  logic [2:0] bit_sel, alu_op;
  logic [7:0] imm_data, rd_data_ff, acc_out, eeprom_ctrl_out, eeprom_status_in, o, v;
  logic [7:0] d0 [16], d2 [16];
  logic [31:0] seed = 32'h5;
  int         fail_count, comparisons, cycles;
  // device and core
  data_memory #(.ID_CODE(ID)) i_data_memory (.*);
  core_model i_core_model (.*);
  function automatic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic [7:0] bitx(input [7:0] b, input [2:0] i, input s);
    b[i] = s;
    return b;
  endfunction
  function automatic [7:0] alu_ref(input [2:0] c, input [7:0] a, input [7:0] m);
    case (c)
      3'h1: return a;
      3'h2: return a + m;
      3'h3: return a - m;
      3'h4: return a & m;
      3'h5: return a | m;
      3'h6: return a ^ m;
      3'h7: return m + 8'h01;
      default: return m;
    endcase
  endfunction
  task chk(input string n, input [7:0] e, input [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input x, input [9:0] a, input [7:0] d);
    i_core_model.op(x, a, d, 3'h1);
  endtask
  task rd(input x, input [9:0] a, input [7:0] e);
    i_core_model.op(x, a, 8'h00, 3'h0);
    #1 chk("rd_data_ff", e, rd_data_ff);
  endtask
  task stop_test;
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    arst_n = 1'b0;
    eeprom_status_in = 8'h00;
    repeat (16) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    // general ram in sectors zero and two, top offset included
    for (int i = 0; i < 16; i++) begin
      o = 8'h87 + 8'(i * 8);
      d0[i] = rnd();
      d2[i] = rnd();
      wr(1'b1, {2'h0, o}, d0[i]);
      wr(1'b1, {2'h2, o}, d2[i]);
    end
    for (int i = 0; i < 16; i++) begin
      o = 8'h87 + 8'(i * 8);
      rd(1'b1, {2'h0, o}, d0[i]);
      rd(1'b1, {2'h2, o}, d2[i]);
    end
    rd(1'b0, 10'h2ff, d0[15]);
    // display bytes and missing places
    wr(1'b1, 10'h180, 8'h3e);
    rd(1'b1, 10'h180, 8'h3e);
    wr(1'b1, 10'h193, 8'hc3);
    wr(1'b1, 10'h194, 8'hff);
    wr(1'b1, 10'h3a0, 8'h55);
    rd(1'b1, 10'h193, 8'hc3);
    rd(1'b1, 10'h194, 8'h00);
    rd(1'b1, 10'h3a0, 8'h00);
    // single-bit set and clear, back to back
    v = rnd();
    wr(1'b0, 10'h085, v);
    for (int b = 0; b < 8; b++) begin
      o = rnd();
      i_core_model.op(1'b0, 10'h085, {5'h0, 3'(b)}, o[0] ? 3'h2 : 3'h3);
      v = bitx(v, 3'(b), o[0]);
      rd(1'b0, 10'h085, v);
    end
    // accumulator load, add, store
    i_core_model.op(1'b0, 10'h000, 8'h21, 3'h4);
    #1 chk("acc_out", 8'h21, acc_out);
    i_core_model.op(1'b0, 10'h000, 8'h0f, 3'h5);
    #1 chk("acc_out", 8'h30, acc_out);
    i_core_model.op(1'b0, 10'h0a0, 8'h00, 3'h6);
    rd(1'b0, 10'h0a0, 8'h30);
    rd(1'b1, 10'h205, 8'h30);
    // alu codes 2 to 7, immediate and memory operands
    v = rnd();
    i_core_model.op(1'b0, 10'h000, v, 3'h4);
    for (int k = 0; k < 12; k++) begin
      o = rnd();
      i_core_model.calc(3'(2 + k % 6), 10'h0a0, o, k < 6, 1'b0);
      v = alu_ref(3'(2 + k % 6), v, (k < 6) ? o : 8'h30);
      #1 chk("acc_out", v, acc_out);
    end
    // port zero through its pointer, sector zero only
    wr(1'b0, 10'h001, 8'h90);
    rd(1'b1, 10'h201, 8'h90);
    wr(1'b1, 10'h290, 8'h11);
    wr(1'b0, 10'h000, 8'h6e);
    rd(1'b0, 10'h090, 8'h6e);
    rd(1'b1, 10'h200, 8'h6e);
    i_core_model.calc(3'h7, 10'h001, 8'h00, 1'b0, 1'b1);
    rd(1'b0, 10'h001, 8'h91);
    // port one into sector two, port two onto the control reg
    wr(1'b0, 10'h003, 8'ha0);
    wr(1'b0, 10'h004, 8'h02);
    wr(1'b0, 10'h002, 8'h77);
    rd(1'b1, 10'h2a0, 8'h77);
    wr(1'b0, 10'h007, 8'h40);
    wr(1'b0, 10'h008, 8'h01);
    wr(1'b0, 10'h006, 8'h5c);
    #1 chk("eeprom_ctrl_out", 8'h5c, eeprom_ctrl_out);
    i_core_model.idle();
    eeprom_status_in = 8'h81;
    rd(1'b0, 10'h006, 8'hdd);
    rd(1'b1, 10'h140, 8'hdd);
    wr(1'b0, 10'h040, 8'h00);
    rd(1'b0, 10'h040, 8'h00);
    chk("eeprom_ctrl_out", 8'h5c, eeprom_ctrl_out);
    // pointer aimed at a port, then at a bad sector
    wr(1'b0, 10'h003, 8'h02);
    wr(1'b0, 10'h004, 8'h00);
    wr(1'b0, 10'h002, 8'h99);
    rd(1'b0, 10'h002, 8'h00);
    wr(1'b0, 10'h003, 8'ha0);
    wr(1'b0, 10'h004, 8'h03);
    rd(1'b0, 10'h002, 8'h00);
    wr(1'b0, 10'h004, 8'h06);
    wr(1'b0, 10'h002, 8'h12);
    rd(1'b0, 10'h002, 8'h00);
    rd(1'b1, 10'h2a0, 8'h77);
    // read-only id ignores a write
    wr(1'b0, 10'h009, ~ID);
    rd(1'b0, 10'h009, ID);
    // reset in mid-run clears read data, accumulator, pointer zero, control reg
    i_core_model.idle();
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    chk("rd_data_ff", 8'h00, rd_data_ff);
    chk("acc_out", 8'h00, acc_out);
    chk("eeprom_ctrl_out", 8'h00, eeprom_ctrl_out);
    rd(1'b0, 10'h001, 8'h00);
    rd(1'b1, 10'h140, 8'h81);
    rd(1'b1, 10'h220, 8'h00);
    i_core_model.idle();
    stop_test();
  end
endmodule

// *** core/addr_resolve.v ***
`include "data_mem_map.vh"
// turns a direct or port address into a final sector and offset
module addr_resolve (
  // address from the instruction
  input  wire [`SEC_W-1:0] dir_sec,
  input  wire [`OFS_W-1:0] dir_ofs,
  input  wire              ext_mode,
  // pointer contents
  input  wire [`DW-1:0]    ptr0,
  input  wire [`DW-1:0]    ptr1_low,
  input  wire [`DW-1:0]    ptr1_sec,
  input  wire [`DW-1:0]    ptr2_low,
  input  wire [`DW-1:0]    ptr2_sec,
  // resolved location
  output reg  [`SEC_W-1:0] eff_sec,
  output reg  [`OFS_W-1:0] eff_ofs,
  output reg               sec_bad,
  output reg               port_self
);
  reg [`DW-1:0] psec;
  // select the pointer when a port is addressed
  always @* begin
    psec      = `SEC_ZERO_BYTE;
    eff_sec   = ext_mode ? dir_sec : `SEC_ZERO;
    eff_ofs   = dir_ofs;
    sec_bad   = 1'b0;
    port_self = 1'b0;
    case (dir_ofs)
      `OFS_PORT0: begin
        eff_sec = `SEC_ZERO;
        eff_ofs = ptr0;
      end
      `OFS_PORT1: begin
        psec    = ptr1_sec;
        eff_ofs = ptr1_low;
      end
      `OFS_PORT2: begin
        psec    = ptr2_sec;
        eff_ofs = ptr2_low;
      end
      default: begin
        psec = `SEC_ZERO_BYTE;
      end
    endcase
    if (dir_ofs == `OFS_PORT1 || dir_ofs == `OFS_PORT2) begin
      eff_sec = psec[`SEC_W-1:0];
      sec_bad = (psec[`DW-1:`SEC_W] != {(`DW-`SEC_W){1'b0}});
    end
    if (dir_ofs == `OFS_PORT0 || dir_ofs == `OFS_PORT1 || dir_ofs == `OFS_PORT2) begin
      port_self = (eff_ofs == `OFS_PORT0) || (eff_ofs == `OFS_PORT1) ||
                  (eff_ofs == `OFS_PORT2);
    end
  end
endmodule

// *** core/byte_reg.v ***
`include "data_mem_map.vh"
// one byte of storage with reset and write strobe
module byte_reg (
  // clock and reset
  input  wire           clk,
  input  wire           arst_n,
  // write side
  input  wire           wr_en,
  input  wire [`DW-1:0] wr_data,
  // stored value
  output reg  [`DW-1:0] q_ff
);
  // plain load register
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff <= `ZERO_BYTE;
    end else if (wr_en) begin
      q_ff <= wr_data;
    end
  end
endmodule

// *** core/data_mem_map.vh ***
`ifndef DATA_MEM_MAP_VH
`define DATA_MEM_MAP_VH
// data width and address split
`define DW            8
`define SEC_W         2
`define OFS_W         8
// sector numbers
`define SEC_ZERO      2'h0
`define SEC_ONE       2'h1
`define SEC_TWO       2'h2
// area boundaries inside a sector
`define SPR_BASE      8'h00
`define GPR_BASE      8'h80
`define LCD_LAST      8'h93
`define LCD_DEPTH     20
`define GPR_DEPTH     128
// special register offsets
`define OFS_PORT0     8'h00
`define OFS_PTR0      8'h01
`define OFS_PORT1     8'h02
`define OFS_P1LOW     8'h03
`define OFS_P1SEC     8'h04
`define OFS_ACC       8'h05
`define OFS_PORT2     8'h06
`define OFS_P2LOW     8'h07
`define OFS_P2SEC     8'h08
`define OFS_IDCODE    8'h09
`define OFS_EECTL     8'h40
// reset and fill values
`define ZERO_BYTE     8'h00
`define SEC_ZERO_BYTE 8'h00
// alu operation codes
`define OP_PASS_M     3'h0
`define OP_PASS_A     3'h1
`define OP_ADD        3'h2
`define OP_SUB        3'h3
`define OP_AND        3'h4
`define OP_OR         3'h5
`define OP_XOR        3'h6
`define OP_INC        3'h7
`endif

// *** core/data_memory.v ***
`include "data_mem_map.vh"
// What this block does
// - every location is one byte wide
// - special area at 00H, general at 80H
// - special registers mirrored; 40H only sector one
// - general ram 80H-FFH in sectors zero, two
// - sector one holds 20 display bytes
// - no bank pointer; pointer pair gives sector
// - extended address is 10 bits, sector:offset
// - extended direct reaches sectors beyond zero
// - full read/write plus single-bit set/clear
// - unused special locations read 00H
// - some special registers are read-only
// - port access redirects to its pointer
// - port zero reaches sector zero only
// - ports one, two reach any sector
// - pointer at a port reads zero, ignores writes
// - five pointers are real read/write storage
// - alu result lands in accumulator or memory
// - register moves pass through the accumulator
// - control reg reached with pointers 40H, 01H
module data_memory (
  // clock and reset
  input  wire               clk,
  input  wire               arst_n,
  // instruction cycle strobe and address
  input  wire               cyc_en,
  input  wire [9:0]         mem_addr,
  input  wire               ext_mode,
  // operation request
  input  wire               rd_en,
  input  wire               wr_mem,
  input  wire               wr_acc,
  input  wire               bit_op,
  input  wire               bit_set,
  input  wire [2:0]         bit_sel,
  input  wire [2:0]         alu_op,
  input  wire [`DW-1:0]     imm_data,
  input  wire               use_imm,
  // read data and accumulator
  output reg  [`DW-1:0]     rd_data_ff,
  output wire [`DW-1:0]     acc_out,
  // eeprom control register link
  output wire [`DW-1:0]     eeprom_ctrl_out,
  input  wire [`DW-1:0]     eeprom_status_in
);
  parameter [`DW-1:0] ID_CODE = 8'h5a; // arbitrary value

  // pointer, accumulator and control reg storage
  wire [`DW-1:0] ptr0_q;
  wire [`DW-1:0] p1low_q;
  wire [`DW-1:0] p1sec_q;
  wire [`DW-1:0] p2low_q;
  wire [`DW-1:0] p2sec_q;
  wire [`DW-1:0] acc_q;
  wire [`DW-1:0] eectl_q;

  // general ram, display ram
  reg  [`DW-1:0] gpr0_mem [0:`GPR_DEPTH-1];
  reg  [`DW-1:0] gpr2_mem [0:`GPR_DEPTH-1];
  reg  [`DW-1:0] lcd_mem  [0:`LCD_DEPTH-1];

  // resolved address
  wire [`SEC_W-1:0] eff_sec;
  wire [`OFS_W-1:0] eff_ofs;
  wire              sec_bad;
  wire              port_self;

  // decode helpers
  reg  [`DW-1:0] cur_val;
  reg  [`DW-1:0] alu_res;
  reg  [`DW-1:0] nxt_mem_val;
  reg  [`DW-1:0] operand;
  reg  [`DW-1:0] bit_mask;
  reg            in_gpr;
  reg            in_lcd;
  reg            in_spr;
  reg            hit_ptr0;
  reg            hit_p1low;
  reg            hit_p1sec;
  reg            hit_p2low;
  reg            hit_p2sec;
  reg            hit_acc;
  reg            hit_eectl;
  reg            spr_write;
  wire           do_wr;
  wire           do_acc;
  wire [6:0]     gpr_idx;
  wire [4:0]     lcd_idx;

  // address split: upper two bits pick the sector
  addr_resolve u_resolve (
    .dir_sec   (mem_addr[`SEC_W+`OFS_W-1:`OFS_W]),
    .dir_ofs   (mem_addr[`OFS_W-1:0]),
    .ext_mode  (ext_mode),
    .ptr0      (ptr0_q),
    .ptr1_low  (p1low_q),
    .ptr1_sec  (p1sec_q),
    .ptr2_low  (p2low_q),
    .ptr2_sec  (p2sec_q),
    .eff_sec   (eff_sec),
    .eff_ofs   (eff_ofs),
    .sec_bad   (sec_bad),
    .port_self (port_self)
  );

  assign gpr_idx = eff_ofs[6:0];
  assign lcd_idx = eff_ofs[4:0];

  // area and register decode
  always @* begin
    in_spr    = (eff_ofs < `GPR_BASE);
    in_gpr    = !in_spr && !sec_bad &&
                (eff_sec == `SEC_ZERO || eff_sec == `SEC_TWO);
    in_lcd    = !in_spr && !sec_bad && (eff_sec == `SEC_ONE) &&
                (eff_ofs <= `LCD_LAST);
    // special registers appear in every sector, 40H in sector one only
    hit_ptr0  = !sec_bad && !port_self && (eff_ofs == `OFS_PTR0);
    hit_p1low = !sec_bad && !port_self && (eff_ofs == `OFS_P1LOW);
    hit_p1sec = !sec_bad && !port_self && (eff_ofs == `OFS_P1SEC);
    hit_p2low = !sec_bad && !port_self && (eff_ofs == `OFS_P2LOW);
    hit_p2sec = !sec_bad && !port_self && (eff_ofs == `OFS_P2SEC);
    hit_acc   = !sec_bad && !port_self && (eff_ofs == `OFS_ACC);
    hit_eectl = !sec_bad && (eff_sec == `SEC_ONE) &&
                (eff_ofs == `OFS_EECTL);
  end

  // current contents of the addressed location
  always @* begin
    cur_val = `ZERO_BYTE;
    if (port_self || sec_bad) begin
      cur_val = `ZERO_BYTE;
    end else if (in_gpr) begin
      cur_val = (eff_sec == `SEC_ZERO) ? gpr0_mem[gpr_idx] : gpr2_mem[gpr_idx];
    end else if (in_lcd) begin
      cur_val = lcd_mem[lcd_idx];
    end else if (hit_ptr0) begin
      cur_val = ptr0_q;
    end else if (hit_p1low) begin
      cur_val = p1low_q;
    end else if (hit_p1sec) begin
      cur_val = p1sec_q;
    end else if (hit_p2low) begin
      cur_val = p2low_q;
    end else if (hit_p2sec) begin
      cur_val = p2sec_q;
    end else if (hit_acc) begin
      cur_val = acc_q;
    end else if (hit_eectl) begin
      cur_val = eectl_q | eeprom_status_in;
    end else if (in_spr && eff_ofs == `OFS_IDCODE) begin
      cur_val = ID_CODE;
    end
  end

  // alu; result goes to accumulator or back to memory through one path
  always @* begin
    operand  = use_imm ? imm_data : cur_val;
    bit_mask = 8'h01 << bit_sel;
    case (alu_op)
      `OP_PASS_M: alu_res = operand;
      `OP_PASS_A: alu_res = acc_q;
      `OP_ADD:    alu_res = acc_q + operand;
      `OP_SUB:    alu_res = acc_q - operand;
      `OP_AND:    alu_res = acc_q & operand;
      `OP_OR:     alu_res = acc_q | operand;
      `OP_XOR:    alu_res = acc_q ^ operand;
      `OP_INC:    alu_res = operand + 8'h01;
      default:    alu_res = operand;
    endcase
    if (bit_op) begin
      nxt_mem_val = bit_set ? (cur_val | bit_mask) : (cur_val & ~bit_mask);
    end else begin
      nxt_mem_val = alu_res;
    end
  end

  // one write per instruction cycle
  assign do_wr  = cyc_en && wr_mem && !port_self && !sec_bad;
  assign do_acc = cyc_en && wr_acc && !bit_op;

  always @* begin
    spr_write = do_wr && in_spr;
  end

  // pointer registers and accumulator
  byte_reg u_ptr0 (.clk(clk), .arst_n(arst_n), .wr_en(spr_write && hit_ptr0),
                   .wr_data(nxt_mem_val), .q_ff(ptr0_q));
  byte_reg u_p1low (.clk(clk), .arst_n(arst_n), .wr_en(spr_write && hit_p1low),
                    .wr_data(nxt_mem_val), .q_ff(p1low_q));
  byte_reg u_p1sec (.clk(clk), .arst_n(arst_n), .wr_en(spr_write && hit_p1sec),
                    .wr_data(nxt_mem_val), .q_ff(p1sec_q));
  byte_reg u_p2low (.clk(clk), .arst_n(arst_n), .wr_en(spr_write && hit_p2low),
                    .wr_data(nxt_mem_val), .q_ff(p2low_q));
  byte_reg u_p2sec (.clk(clk), .arst_n(arst_n), .wr_en(spr_write && hit_p2sec),
                    .wr_data(nxt_mem_val), .q_ff(p2sec_q));
  // accumulator takes alu results and memory writes to its own offset
  byte_reg u_acc (.clk(clk), .arst_n(arst_n),
                  .wr_en(do_acc || (spr_write && hit_acc)),
                  .wr_data(do_acc ? alu_res : nxt_mem_val), .q_ff(acc_q));
  byte_reg u_eectl (.clk(clk), .arst_n(arst_n), .wr_en(spr_write && hit_eectl),
                    .wr_data(nxt_mem_val), .q_ff(eectl_q));

  // ram arrays keep no reset, like real cells
  always @(posedge clk) begin
    if (do_wr && in_gpr && eff_sec == `SEC_ZERO) begin
      gpr0_mem[gpr_idx] <= nxt_mem_val;
    end
    if (do_wr && in_gpr && eff_sec == `SEC_TWO) begin
      gpr2_mem[gpr_idx] <= nxt_mem_val;
    end
    if (do_wr && in_lcd) begin
      lcd_mem[lcd_idx] <= nxt_mem_val;
    end
  end

  // registered read data, one cycle after the request
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_ff <= `ZERO_BYTE;
    end else if (cyc_en && rd_en) begin
      rd_data_ff <= cur_val;
    end
  end

  assign acc_out         = acc_q;
  assign eeprom_ctrl_out = eectl_q;
endmodule
